/* File: bcmd_top.sv */
`timescale 1ns/100ps

module bcmd_top #(
    parameter int NV_BUSY_CYCLES = bcmd_pkg::NV_BUSY_CYCLES
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        resetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Byte link from the bit-slot layer
    input  wire logic        link_reset,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_byte,
    input  wire logic        tx_req,
    output logic             tx_valid,
    output logic      [7:0]  tx_byte,
    // Temperature sensor result
    input  wire logic [7:0]  temp_half_in,
    input  wire logic [7:0]  temp_whole_in,
    // Status outputs
    output logic             eeprom_busy_flag,
    output logic             temp_busy_flag
);

    typedef struct packed {
        bcmd_pkg::bcmd_fsm_t                  fsm;
        logic [7:0]                           cmd;
        logic [7:0]                           ptr;
        logic [bcmd_pkg::PAGE1_BYTES-1:0][7:0] scratch_page_one;
        logic [bcmd_pkg::PAGE2_BYTES-1:0][7:0] scratch_page_two;
        logic [bcmd_pkg::PAGE3_BYTES-1:0][7:0] scratch_page_three;
        logic [bcmd_pkg::PAGE1_BYTES-1:0][7:0] eeprom_page_one;
        logic [bcmd_pkg::PAGE2_BYTES-1:0][7:0] eeprom_page_two;
        logic [bcmd_pkg::PAGE3_BYTES-1:0][7:0] sram_page;
        logic                                 lock;
        logic                                 ee_busy;
        logic [bcmd_pkg::NV_CNT_W-1:0]        nv_cnt;
        logic                                 temp_busy;
        logic [bcmd_pkg::CONV_CNT_W-1:0]      conv_cnt;
        logic [7:0]                           temp_half;
        logic [7:0]                           temp_whole;
        logic [15:0]                          cycle;
        logic [15:0]                          wear;
        logic                                 link_en;
        logic                                 tx_valid;
        logic [7:0]                           tx_byte;
        logic [31:0]                          prdata;
        logic                                 pready;
        logic                                 pslverr;
    } bcmd_state_t;

    bcmd_state_t s_q;
    bcmd_state_t s_d;

    localparam logic [bcmd_pkg::NV_CNT_W-1:0] NV_LOAD =
        bcmd_pkg::NV_CNT_W'(NV_BUSY_CYCLES - 1);
    localparam logic [bcmd_pkg::CONV_CNT_W-1:0] CONV_LOAD =
        bcmd_pkg::CONV_CNT_W'(bcmd_pkg::CONV_CYCLES - 1);
    localparam logic [15:0] WEAR_MAX = 16'(bcmd_pkg::WEAR_LIMIT);

    function automatic logic [7:0] status_byte(input bcmd_state_t s);
        logic [7:0] b;
        b = 8'h00;
        b[bcmd_pkg::STAT_TEMP_BUSY] = s.temp_busy;
        b[bcmd_pkg::STAT_EE_BUSY]   = s.ee_busy;
        b[bcmd_pkg::STAT_LOCK]      = s.lock;
        return b;
    endfunction

    // Scratch space only; eeprom and static pages have no path here
    function automatic logic [7:0] scratch_byte(input bcmd_state_t s, input logic [7:0] a);
        logic [7:0] r;
        r = bcmd_pkg::FILL_BYTE;
        if (a < bcmd_pkg::PAGE1_BASE + 8'(bcmd_pkg::PAGE1_BYTES)) begin
            r = s.scratch_page_one[5'(a)];
        end else if (a >= bcmd_pkg::PAGE2_BASE &&
                     a < bcmd_pkg::PAGE2_BASE + 8'(bcmd_pkg::PAGE2_BYTES)) begin
            r = s.scratch_page_two[3'(a - bcmd_pkg::PAGE2_BASE)];
        end else if (a >= bcmd_pkg::PAGE3_BASE && a <= bcmd_pkg::SCRATCH_END) begin
            r = s.scratch_page_three[5'(a - bcmd_pkg::PAGE3_BASE)];
        end
        return r;
    endfunction

    function automatic logic [7:0] reg_byte(input bcmd_state_t s, input logic [7:0] a);
        logic [7:0] r;
        r = bcmd_pkg::FILL_BYTE;
        case (a)
            bcmd_pkg::REG_TEMP_HALF:  r = s.temp_half;
            bcmd_pkg::REG_TEMP_WHOLE: r = s.temp_whole;
            bcmd_pkg::REG_STATUS_LO:  r = status_byte(s);
            bcmd_pkg::REG_STATUS_HI:  r = 8'h00;
            bcmd_pkg::REG_ID_LO:      r = bcmd_pkg::ID_CODE[7:0];
            bcmd_pkg::REG_ID_HI:      r = bcmd_pkg::ID_CODE[15:8];
            bcmd_pkg::REG_CYCLE_LO:   r = s.cycle[7:0];
            bcmd_pkg::REG_CYCLE_HI:   r = s.cycle[15:8];
            default:                  r = bcmd_pkg::FILL_BYTE;
        endcase
        return r;
    endfunction

    always_comb begin
        logic [7:0] a;
        logic       nv_commit;
        s_d       = s_q;
        a         = s_q.ptr;
        nv_commit = 1'b0;
        s_d.tx_valid = 1'b0;

        // Conversion runs beside the command machine, so nothing waits on it
        if (s_q.temp_busy) begin
            if (s_q.conv_cnt == '0) begin
                s_d.temp_busy  = 1'b0;
                s_d.temp_half  = temp_half_in;
                s_d.temp_whole = temp_whole_in;
            end else begin
                s_d.conv_cnt = s_q.conv_cnt - 1'b1;
            end
        end

        if (s_q.ee_busy) begin
            if (s_q.nv_cnt == '0) begin
                s_d.ee_busy = 1'b0;
            end else begin
                s_d.nv_cnt = s_q.nv_cnt - 1'b1;
            end
        end

        // Bytes arrive already assembled with the first wire bit in bit 0
        if (link_reset && s_q.link_en) begin
            s_d.fsm = bcmd_pkg::ST_CMD;
        end else if (s_q.link_en) begin
            case (s_q.fsm)
                bcmd_pkg::ST_CMD: begin
                    if (rx_valid) begin
                        s_d.cmd = rx_byte;
                        s_d.fsm = bcmd_pkg::ST_IGNORE;
                        case (rx_byte)
                            bcmd_pkg::CMD_READ_SCRATCH,
                            bcmd_pkg::CMD_WRITE_SCRATCH,
                            bcmd_pkg::CMD_READ_REGS: begin
                                s_d.fsm = bcmd_pkg::ST_ADDR;
                            end
                            bcmd_pkg::CMD_SAVE_PAGE1: begin
                                if (!s_q.lock) begin
                                    s_d.eeprom_page_one = s_q.scratch_page_one;
                                    nv_commit = 1'b1;
                                end
                            end
                            bcmd_pkg::CMD_SAVE_PAGE2: begin
                                s_d.eeprom_page_two = s_q.scratch_page_two;
                                nv_commit = 1'b1;
                            end
                            bcmd_pkg::CMD_SAVE_PAGE3: begin
                                s_d.sram_page = s_q.scratch_page_three;
                            end
                            bcmd_pkg::CMD_LOAD_PAGE1: begin
                                s_d.scratch_page_one = s_q.eeprom_page_one;
                            end
                            bcmd_pkg::CMD_LOAD_PAGE2: begin
                                s_d.scratch_page_two = s_q.eeprom_page_two;
                            end
                            bcmd_pkg::CMD_LOAD_PAGE3: begin
                                s_d.scratch_page_three = s_q.sram_page;
                            end
                            bcmd_pkg::CMD_LOCK: begin
                                s_d.lock = 1'b1;
                            end
                            bcmd_pkg::CMD_UNLOCK: begin
                                s_d.lock = 1'b0;
                            end
                            bcmd_pkg::CMD_CONVERT_T: begin
                                s_d.temp_busy = 1'b1;
                                s_d.conv_cnt  = CONV_LOAD;
                            end
                            bcmd_pkg::CMD_INC_CYCLE: begin
                                s_d.cycle = s_q.cycle + 16'h0001;
                                nv_commit = 1'b1;
                            end
                            bcmd_pkg::CMD_CLR_CYCLE: begin
                                s_d.cycle = 16'h0000;
                                nv_commit = 1'b1;
                            end
                            default: begin
                                s_d.fsm = bcmd_pkg::ST_IGNORE;
                            end
                        endcase
                    end
                end
                bcmd_pkg::ST_ADDR: begin
                    if (rx_valid) begin
                        s_d.ptr = rx_byte;
                        s_d.fsm = (s_q.cmd == bcmd_pkg::CMD_WRITE_SCRATCH) ?
                                  bcmd_pkg::ST_WRITE : bcmd_pkg::ST_READ;
                    end
                end
                bcmd_pkg::ST_WRITE: begin
                    if (rx_valid) begin
                        if (a < bcmd_pkg::PAGE1_BASE + 8'(bcmd_pkg::PAGE1_BYTES)) begin
                            s_d.scratch_page_one[5'(a)] = rx_byte;
                        end else if (a >= bcmd_pkg::PAGE2_BASE &&
                                     a < bcmd_pkg::PAGE2_BASE + 8'(bcmd_pkg::PAGE2_BYTES)) begin
                            s_d.scratch_page_two[3'(a - bcmd_pkg::PAGE2_BASE)] = rx_byte;
                        end else if (a >= bcmd_pkg::PAGE3_BASE && a <= bcmd_pkg::SCRATCH_END) begin
                            s_d.scratch_page_three[5'(a - bcmd_pkg::PAGE3_BASE)] = rx_byte;
                        end
                        // Saturate so a long burst never wraps onto page one
                        if (a != 8'hFF) begin
                            s_d.ptr = a + 8'h01;
                        end
                    end
                end
                bcmd_pkg::ST_READ: begin
                    if (tx_req) begin
                        s_d.tx_valid = 1'b1;
                        s_d.tx_byte  = (s_q.cmd == bcmd_pkg::CMD_READ_REGS) ?
                                       reg_byte(s_q, a) : scratch_byte(s_q, a);
                        if (a != 8'hFF) begin
                            s_d.ptr = a + 8'h01;
                        end
                    end
                end
                default: begin
                    s_d.fsm = bcmd_pkg::ST_IGNORE;
                end
            endcase
        end

        // Each commit restarts the busy window and counts toward endurance until the wear count holds at WEAR_MAX
        if (nv_commit) begin
            s_d.ee_busy = 1'b1;
            s_d.nv_cnt  = NV_LOAD;
            if (s_q.wear != WEAR_MAX) begin
                s_d.wear = s_q.wear + 16'h0001;
            end
        end

        // APB: answer in the first access cycle, no wait states
        // Error flag pulses with pready so it never outlives its transfer
        s_d.pready  = psel && !penable;
        s_d.pslverr = 1'b0;
        if (psel && !penable) begin
            s_d.prdata  = 32'h0000_0000;
            case (paddr)
                bcmd_pkg::APB_CTRL:   s_d.prdata[bcmd_pkg::CTRL_LINK_EN] = s_q.link_en;
                bcmd_pkg::APB_STATUS: begin
                    s_d.prdata[7:0] = status_byte(s_q);
                    s_d.prdata[bcmd_pkg::STATUS_WEAR] = (s_q.wear == WEAR_MAX);
                end
                bcmd_pkg::APB_CYCLE:  s_d.prdata[15:0] = s_q.cycle;
                bcmd_pkg::APB_WEAR:   s_d.prdata[15:0] = s_q.wear;
                bcmd_pkg::APB_TEMP:   s_d.prdata[15:0] = {s_q.temp_whole, s_q.temp_half};
                default:              s_d.pslverr = 1'b1;
            endcase
        end
        if (psel && penable && s_q.pready && pwrite && paddr == bcmd_pkg::APB_CTRL) begin
            s_d.link_en = pwrite ? pwdata[bcmd_pkg::CTRL_LINK_EN] : s_q.link_en;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s_q         <= '0;
            s_q.link_en <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata           = s_q.prdata;
    assign pready           = s_q.pready;
    assign pslverr          = s_q.pslverr;
    assign tx_valid         = s_q.tx_valid;
    assign tx_byte          = s_q.tx_byte;
    assign eeprom_busy_flag = s_q.ee_busy;
    assign temp_busy_flag   = s_q.temp_busy;

endmodule

/* File: bcmd_pkg.sv */
package bcmd_pkg;

    // Command bytes
    localparam logic [7:0] CMD_READ_SCRATCH  = 8'h11;
    localparam logic [7:0] CMD_WRITE_SCRATCH = 8'h17;
    localparam logic [7:0] CMD_SAVE_PAGE1    = 8'h22;
    localparam logic [7:0] CMD_SAVE_PAGE2    = 8'h25;
    localparam logic [7:0] CMD_SAVE_PAGE3    = 8'h28;
    localparam logic [7:0] CMD_LOAD_PAGE1    = 8'h71;
    localparam logic [7:0] CMD_LOAD_PAGE2    = 8'h77;
    localparam logic [7:0] CMD_LOAD_PAGE3    = 8'h7A;
    localparam logic [7:0] CMD_LOCK          = 8'h43;
    localparam logic [7:0] CMD_UNLOCK        = 8'h44;
    localparam logic [7:0] CMD_CONVERT_T     = 8'hD2;
    localparam logic [7:0] CMD_READ_REGS     = 8'hB2;
    localparam logic [7:0] CMD_INC_CYCLE     = 8'hB5;
    localparam logic [7:0] CMD_CLR_CYCLE     = 8'hB8;

    // Page sizes and bases in the link address space
    localparam int         PAGE1_BYTES = 24;
    localparam int         PAGE2_BYTES = 8;
    localparam int         PAGE3_BYTES = 32;
    localparam logic [7:0] PAGE1_BASE  = 8'h00;
    localparam logic [7:0] PAGE2_BASE  = 8'h20;
    localparam logic [7:0] PAGE3_BASE  = 8'h40;
    localparam logic [7:0] SCRATCH_END = 8'h5F;

    // Register page addresses
    localparam logic [7:0] REG_TEMP_HALF  = 8'h60;
    localparam logic [7:0] REG_TEMP_WHOLE = 8'h61;
    localparam logic [7:0] REG_STATUS_LO  = 8'h62;
    localparam logic [7:0] REG_STATUS_HI  = 8'h63;
    localparam logic [7:0] REG_ID_LO      = 8'h80;
    localparam logic [7:0] REG_ID_HI      = 8'h81;
    localparam logic [7:0] REG_CYCLE_LO   = 8'h82;
    localparam logic [7:0] REG_CYCLE_HI   = 8'h83;
    localparam logic [7:0] FILL_BYTE      = 8'hFF;

    // Status byte bit positions
    localparam int STAT_TEMP_BUSY = 0;
    localparam int STAT_EE_BUSY   = 1;
    localparam int STAT_LOCK      = 2;

    // Timing
    localparam int CLK_KHZ        = 125000;
    localparam int NV_BUSY_MS     = 10;
    localparam int NV_BUSY_CYCLES = NV_BUSY_MS * CLK_KHZ;
    localparam int NV_CNT_W       = 21;
    localparam int CONV_CYCLES    = 1000;
    localparam int CONV_CNT_W     = 16;
    localparam int WEAR_LIMIT     = 50000;

    // Manufacturer code, arbitrary value
    localparam logic [15:0] ID_CODE = 16'h5A3C;

    // APB register byte offsets
    localparam logic [7:0] APB_CTRL   = 8'h00;
    localparam logic [7:0] APB_STATUS = 8'h04;
    localparam logic [7:0] APB_CYCLE  = 8'h08;
    localparam logic [7:0] APB_WEAR   = 8'h0C;
    localparam logic [7:0] APB_TEMP   = 8'h10;
    localparam int         CTRL_LINK_EN = 0;
    localparam int         STATUS_WEAR  = 3;

    typedef enum logic [2:0] {
        ST_IGNORE = 3'b000,
        ST_CMD    = 3'b001,
        ST_ADDR   = 3'b010,
        ST_WRITE  = 3'b011,
        ST_READ   = 3'b100
    } bcmd_fsm_t;

endpackage

/* File: bcmd_checker_assertions.sv */
`timescale 1ns/100ps
module bcmd_checker #(
    parameter int NV_BUSY_CYCLES = bcmd_pkg::NV_BUSY_CYCLES
) (
    // Clock and reset
    input wire logic        clock,
    input wire logic        resetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Byte link
    input wire logic        rx_valid,
    input wire logic [7:0]  rx_byte,
    input wire logic        tx_req,
    input wire logic        tx_valid,
    // Flags
    input wire logic        eeprom_busy_flag,
    input wire logic        temp_busy_flag
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    int busy_len_q;
    // Counts only unbroken busy runs; a restart may lengthen one
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            busy_len_q <= 0;
        end else if (eeprom_busy_flag) begin
            busy_len_q <= busy_len_q + 1;
        end else begin
            busy_len_q <= 0;
        end
    end
    sequence apb_setup;
        psel && !penable;
    endsequence
    sequence conv_run;
        temp_busy_flag [*8] ##[1:993] !temp_busy_flag;
    endsequence
    a_apb_answer: assert property (apb_setup |=> pready)
        else $error("no answer after setup");
    a_pready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_slverr_zero: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error response malformed");
    a_tx_answer: assert property (tx_valid |-> $past(tx_req))
        else $error("byte sent without request");
    a_ee_busy_cause: assert property ($rose(eeprom_busy_flag) |->
        $past(rx_valid && rx_byte inside {8'h22, 8'h25, 8'hB5, 8'hB8}))
        else $error("busy without commit command");
    a_ee_busy_span: assert property ($fell(eeprom_busy_flag) |-> busy_len_q >= NV_BUSY_CYCLES)
        else $error("busy window too short");
    a_conv_cause: assert property ($rose(temp_busy_flag) |->
        $past(rx_valid) && $past(rx_byte) == 8'hD2)
        else $error("conversion without command");
    a_conv_end: assert property ($rose(temp_busy_flag) |-> conv_run)
        else $error("conversion length wrong");
endmodule

/* File: bcmd_link_master.sv */
`timescale 1ns/100ps
module bcmd_link_master (
    // Clock
    input  wire logic       clock,
    // Byte link toward the device
    output logic            link_reset,
    output logic            rx_valid,
    output logic [7:0]      rx_byte,
    output logic            tx_req,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_byte
);
    initial begin
        link_reset = 1'b0;
        rx_valid = 1'b0;
        rx_byte = 8'h00;
        tx_req = 1'b0;
    end
    task automatic bus_reset();
        @(posedge clock);
        link_reset <= 1'b1;
        @(posedge clock);
        link_reset <= 1'b0;
    endtask
    // Bit 0 is the first wire bit; released data never keeps the old value
    task automatic send(input logic [7:0] b);
        @(posedge clock);
        rx_valid <= 1'b1;
        rx_byte <= b;
        @(posedge clock);
        rx_valid <= 1'b0;
        rx_byte <= ~b;
    endtask
    task automatic recv(output logic [7:0] b, output logic ok);
        @(posedge clock);
        tx_req <= 1'b1;
        @(posedge clock);
        tx_req <= 1'b0;
        ok = 1'b0;
        for (int n = 0; n < 4 && !ok; n++) begin
            @(posedge clock);
            ok = (tx_valid === 1'b1);
        end
        b = tx_byte;
    endtask
endmodule

/* File: test_battery_tag_memory_commands.sv */
`timescale 1ns/100ps
module test_battery_tag_memory_commands;
    localparam int BUSY_LEN = 20;
    typedef logic [7:0] bcmd_bytes_t[$];
    logic        clock = 1'b0;
    logic        resetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, link_reset, rx_valid, tx_req, tx_valid;
    logic [7:0]  rx_byte, tx_byte;
    logic        eeprom_busy, temp_busy;
    logic [7:0]  t_half = 8'h35;
    logic [7:0]  t_whole = 8'hC4;
    int          fail_count = 0;
    int          checked = 0;
    always #4 clock = ~clock;
    bcmd_top #(.NV_BUSY_CYCLES(BUSY_LEN)) dut_u (.clock(clock), .resetn(resetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_reset(link_reset),
        .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_req(tx_req), .tx_valid(tx_valid),
        .tx_byte(tx_byte), .temp_half_in(t_half), .temp_whole_in(t_whole),
        .eeprom_busy_flag(eeprom_busy), .temp_busy_flag(temp_busy));
    bcmd_link_master m_u (.clock(clock), .link_reset(link_reset), .rx_valid(rx_valid),
        .rx_byte(rx_byte), .tx_req(tx_req), .tx_valid(tx_valid), .tx_byte(tx_byte));
    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rreg(input logic [7:0] a, input logic [31:0] e, input logic ee);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= a;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        check(32'(pready), 32'h1);
        check(prdata, e);
        check(32'(pslverr), 32'(ee));
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= 1'b1;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        check(32'(pready), 32'h1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic cmd(input logic [7:0] c);
        m_u.bus_reset();
        m_u.send(c);
    endtask
    function automatic bcmd_bytes_t mkq(input logic [7:0] p, input int n, input int live);
        bcmd_bytes_t q;
        for (int i = 0; i < n; i++) begin
            q.push_back(i < live ? p + 8'(i) : 8'hFF);
        end
        return q;
    endfunction
    task automatic fill(input logic [7:0] a, input int n, input logic [7:0] p);
        cmd(8'h17);
        m_u.send(a);
        for (int i = 0; i < n; i++) begin
            m_u.send(p + 8'(i));
        end
    endtask
    task automatic rd(input logic [7:0] c, input logic [7:0] a, input bcmd_bytes_t e);
        logic [7:0] b;
        logic       ok;
        cmd(c);
        m_u.send(a);
        foreach (e[i]) begin
            m_u.recv(b, ok);
            check(32'(ok), 32'h1);
            check(32'(b), 32'(e[i]));
        end
    endtask
    // Busy length counted from the edge that takes the command byte
    task automatic nv_wait(input int exp);
        int k;
        k = 0;
        @(posedge clock);
        while (eeprom_busy === 1'b1 && k < 100) begin
            k++;
            @(posedge clock);
        end
        check(32'(k), 32'(exp));
    endtask
    task automatic page(input logic [7:0] a, input int n, input logic [7:0] to_c,
                        input logic [7:0] back_c, input int busy);
        fill(a, n, a + 8'h31);
        rd(8'h11, a, mkq(a + 8'h31, n, n));
        cmd(to_c);
        nv_wait(busy);
        fill(a, n, 8'hE0);
        rd(8'h11, a, mkq(8'hE0, 1, 1));
        cmd(back_c);
        rd(8'h11, a, mkq(a + 8'h31, n, n));
    endtask
    initial begin
        logic [7:0] b;
        logic       ok;
        int         n;
        repeat (12) @(posedge clock);
        resetn <= 1'b1;
        rreg(bcmd_pkg::APB_CTRL, 32'h1, 1'b0);
        rreg(8'h14, 32'h0, 1'b1);
        // Link disabled: a lock command must leave no trace
        wreg(bcmd_pkg::APB_CTRL, 32'h0);
        cmd(8'h43);
        rreg(bcmd_pkg::APB_CTRL, 32'h0, 1'b0);
        wreg(bcmd_pkg::APB_CTRL, 32'h1);
        rreg(bcmd_pkg::APB_STATUS, 32'h0, 1'b0);
        cmd(8'h99);
        m_u.send(8'h17);
        m_u.recv(b, ok);
        check(32'(ok), 32'h0);
        fill(8'h16, 4, 8'hA0);
        rd(8'h11, 8'h16, mkq(8'hA0, 4, 2));
        fill(8'h5E, 2, 8'hC1);
        rd(8'h11, 8'h5E, mkq(8'hC1, 3, 2));
        cmd(8'hD2);
        rd(8'hB2, 8'h62, '{8'h01});
        page(8'h00, 24, 8'h22, 8'h71, BUSY_LEN);
        page(8'h20, 8, 8'h25, 8'h77, BUSY_LEN);
        page(8'h40, 32, 8'h28, 8'h7A, 0);
        n = 0;
        while (temp_busy === 1'b1 && n < 1100) begin
            @(posedge clock);
            n++;
        end
        check(32'(temp_busy), 32'h0);
        rd(8'hB2, 8'h60, '{8'h35, 8'hC4, 8'h00, 8'h00, 8'hFF});
        // Sensor moves after the conversion: registers keep the loaded result
        t_half <= 8'h12;
        t_whole <= 8'h34;
        rreg(bcmd_pkg::APB_TEMP, 32'h0000_C435, 1'b0);
        cmd(8'h43);
        rd(8'hB2, 8'h62, '{8'h04});
        rreg(bcmd_pkg::APB_STATUS, 32'h4, 1'b0);
        fill(8'h00, 1, 8'h77);
        cmd(8'h22);
        nv_wait(0);
        cmd(8'h71);
        rd(8'h11, 8'h00, '{8'h31});
        cmd(8'h44);
        cmd(8'h22);
        nv_wait(BUSY_LEN);
        cmd(8'hB5);
        nv_wait(BUSY_LEN);
        cmd(8'hB5);
        nv_wait(BUSY_LEN);
        rd(8'hB2, 8'h80, '{bcmd_pkg::ID_CODE[7:0], bcmd_pkg::ID_CODE[15:8],
            8'h02, 8'h00, 8'hFF});
        rreg(bcmd_pkg::APB_CYCLE, 32'h2, 1'b0);
        cmd(8'hB8);
        nv_wait(BUSY_LEN);
        rd(8'hB2, 8'h82, '{8'h00, 8'h00, 8'hFF});
        rreg(bcmd_pkg::APB_WEAR, 32'h6, 1'b0);
        conclude();
    end
    // Whole sequence needs about thirteen hundred cycles
    initial begin
        #160000;
        fail_count++;
        $display("unexpected at %0t: watchdog expired", $time);
        conclude();
    end
endmodule
bind bcmd_top bcmd_checker #(.NV_BUSY_CYCLES(NV_BUSY_CYCLES)) chk_u (.clock(clock),
    .resetn(resetn), .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_req(tx_req),
    .tx_valid(tx_valid), .eeprom_busy_flag(eeprom_busy_flag),
    .temp_busy_flag(temp_busy_flag));
